// >>> pcicfg_arb_model.sv
`timescale 1ns/100ps
// Bus-master logic and central arbiter as the latency logic sees them
module pcicfg_arb_model
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic go,
  input  wire logic grant_off,
  input  wire logic stall,
  input  wire logic burst_stop,
  output logic      frame_start,
  output logic      burst_done,
  output logic      gnt_n
);
  // Registered like real master logic; stall models a slow bus release
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      frame_start <= 1'b0;
      burst_done  <= 1'b0;
      gnt_n       <= 1'b1;
    end
    else
    begin
      frame_start <= go;
      gnt_n       <= grant_off;
      burst_done  <= burst_stop & ~burst_done & ~stall;
    end
  end
endmodule

// >>> pcicfg_header.sv
`timescale 1ns/100ps
module pcicfg_header
  import pcicfg_pkg::*;
#(
  parameter logic [7:0] INTERVAL_RESET = 8'h00
)
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        cfg_rd,
  input  wire logic        cfg_wr,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_ack,
  input  wire logic        frame_start,
  input  wire logic        burst_done,
  input  wire logic        gnt_n,
  input  wire logic        eeprom_load,
  input  wire logic [7:0]  eeprom_setup_field,
  output logic      [7:0]  irq_routing_byte,
  output logic      [23:0] io_window_base,
  output logic             io_base_valid_flag,
  output logic      [7:0]  bus_hold_limit,
  output logic      [7:0]  access_interval_need,
  output logic             burst_stop
);

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic [5:0]  dw_sel;
  logic        hit_hold;
  logic        hit_io;
  logic        hit_irq;
  logic        mapped;
  logic        wr_irq_line;
  logic        wr_hold;
  logic        wr_io_flag;
  logic [2:0]  wr_io_bytes;
  logic [31:0] rd_mux;

  // Dword index; byte lanes pick the field inside it
  assign dw_sel      = cfg_addr[7:2];
  assign hit_hold    = (dw_sel == PCICFG_DW_HOLD);
  assign hit_io      = (dw_sel == PCICFG_DW_IO);
  assign hit_irq     = (dw_sel == PCICFG_DW_IRQ);
  assign mapped      = hit_hold | hit_io | hit_irq;
  assign wr_irq_line = cfg_wr & hit_irq & cfg_be[PCICFG_OFS_IRQ_LINE[1:0]];
  assign wr_hold     = cfg_wr & hit_hold & cfg_be[PCICFG_OFS_HOLD_LIMIT[1:0]];
  assign wr_io_flag  = cfg_wr & hit_io & cfg_be[0];
  assign wr_io_bytes = {3{cfg_wr & hit_io}} & cfg_be[3:1];

  // Read data; unmapped dwords and absent bytes read zero
  assign rd_mux = hit_irq  ? {access_interval_need, PCICFG_ZERO_BYTE,
                              PCICFG_IRQ_PIN_VAL, irq_routing_byte} :
                  hit_io   ? {io_window_base, PCICFG_IO_RSVD, io_base_valid_flag} :
                  hit_hold ? {PCICFG_ZERO_BYTE, PCICFG_ZERO_BYTE, bus_hold_limit,
                              PCICFG_ZERO_BYTE} :
                             32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus answer, one clock after the access

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cfg_rdata <= 32'h0000_0000;
      cfg_ack   <= 1'b0;
    end
    else
    begin
      cfg_rdata <= cfg_rd ? rd_mux : 32'h0000_0000;
      cfg_ack   <= (cfg_rd | cfg_wr) & mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt routing and bus hold limit

  // Reserved low bits of the hold limit never store a one
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      irq_routing_byte <= PCICFG_IRQ_LINE_RST;
      bus_hold_limit   <= PCICFG_HOLD_RST;
    end
    else
    begin
      if (wr_irq_line)
        irq_routing_byte <= cfg_wdata[7:0];
      if (wr_hold)
        bus_hold_limit <= cfg_wdata[15:8] & PCICFG_HOLD_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // I/O window base, one byte lane per address byte

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      io_base_valid_flag <= PCICFG_IO_VALID_RST;
    else if (wr_io_flag)
      io_base_valid_flag <= cfg_wdata[0];
  end

  // Bits 7:1 have no storage, so the window is always 256 bytes
  // Each lane owns its own flop so no variable has two processes writing it
  for (genvar b = 0; b < 3; b++)
  begin : g_io_byte
    logic [7:0] byte_q;

    always_ff @(posedge clk)
    begin
      if (!reset_n)
        byte_q <= PCICFG_IO_ADDR_RST[8*b +: 8];
      else if (wr_io_bytes[b])
        byte_q <= cfg_wdata[8*(b+1) +: 8];
    end

    assign io_window_base[8*b +: 8] = byte_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Access interval byte, loaded during auto-initialization

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      access_interval_need <= INTERVAL_RESET;
    else if (eeprom_load)
      access_interval_need <= eeprom_setup_field;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Grant pin synchroniser; idles deasserted (high)

  logic gnt_meta_q;
  logic gnt_sync_q;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      gnt_meta_q <= 1'b1;
      gnt_sync_q <= 1'b1;
    end
    else
    begin
      gnt_meta_q <= gnt_n;
      gnt_sync_q <= gnt_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Latency counter and bus release

  pcicfg_state_e state_q;
  pcicfg_state_e state_d;
  logic [7:0]    cnt_q;
  logic [7:0]    cnt_d;
  logic [7:0]    load_val;
  logic          stop_d;

  // Limit bits 7:3 times eight is the byte with its low bits clear
  assign load_val = bus_hold_limit & PCICFG_HOLD_MASK;

  // A new FRAME# always wins, so back-to-back transactions restart cleanly
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    if (frame_start)
    begin
      cnt_d   = load_val;
      state_d = (load_val == 8'h00) ? PCICFG_EXPIRED : PCICFG_COUNT;
    end
    else
    begin
      unique case (state_q)
        PCICFG_IDLE:
          state_d = PCICFG_IDLE;
        PCICFG_COUNT:
        begin
          cnt_d = cnt_q - 8'h01;
          if (burst_done)
            state_d = PCICFG_IDLE;
          else if (cnt_q == 8'h01)
            state_d = PCICFG_EXPIRED;
        end
        PCICFG_EXPIRED:
          if (burst_done)
            state_d = PCICFG_IDLE;
        default:
          state_d = PCICFG_IDLE;
      endcase
    end
  end

  // Stop only while expired with grant gone; held until the master ends
  assign stop_d = (state_q == PCICFG_EXPIRED) & gnt_sync_q & ~frame_start
                  & ~burst_done;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_q    <= PCICFG_IDLE;
      cnt_q      <= 8'h00;
      burst_stop <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      burst_stop <= stop_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  irq_line_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_irq_line |=> irq_routing_byte == $past(cfg_wdata[7:0]))
    else $error("routing byte did not take the write");

  irq_pin_const_a: assert property (@(posedge clk) disable iff (!reset_n)
    cfg_rd && hit_irq |=> cfg_rdata[15:8] == PCICFG_IRQ_PIN_VAL)
    else $error("interrupt pin byte not constant");

  io_low_bits_a: assert property (@(posedge clk) disable iff (!reset_n)
    cfg_rd && hit_io |=> cfg_rdata[7:1] == PCICFG_IO_RSVD
                         && cfg_rdata[31:8] == $past(io_window_base))
    else $error("io base read shows wrong bits");

  io_flag_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_io_flag |=> io_base_valid_flag == $past(cfg_wdata[0]))
    else $error("io valid flag did not follow write");

  io_reset_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    $past(!reset_n) |-> io_window_base == PCICFG_IO_ADDR_RST && !io_base_valid_flag)
    else $error("io base not zero after reset");

  hold_low_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    wr_hold |=> bus_hold_limit[2:0] == 3'h0
                && bus_hold_limit[7:3] == $past(cfg_wdata[15:11]))
    else $error("hold limit write wrong");

  frame_restart_a: assert property (@(posedge clk) disable iff (!reset_n)
    frame_start |=> cnt_q == $past(load_val))
    else $error("counter not restarted on frame");

  release_bus_a: assert property (@(posedge clk) disable iff (!reset_n)
    state_q == PCICFG_EXPIRED && gnt_sync_q && !frame_start && !burst_done
    |=> burst_stop)
    else $error("bus not released after expiry");

  interval_load_a: assert property (@(posedge clk) disable iff (!reset_n)
    eeprom_load |=> access_interval_need == $past(eeprom_setup_field))
    else $error("interval byte not loaded");

  count_eight_a: assert property (@(posedge clk) disable iff (!reset_n)
    frame_start && load_val == 8'h08 ##1 (!frame_start && !burst_done)[*8]
    |=> state_q == PCICFG_EXPIRED)
    else $error("count of eight did not expire on time");

  zero_expires_a: assert property (@(posedge clk) disable iff (!reset_n)
    frame_start && load_val == 8'h00 |=> state_q == PCICFG_EXPIRED)
    else $error("zero limit did not expire at once");

  irq_reset_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    $past(!reset_n) |-> irq_routing_byte == PCICFG_IRQ_LINE_RST)
    else $error("routing byte not zero after reset");

  hold_reset_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    $past(!reset_n) |-> bus_hold_limit == PCICFG_HOLD_RST)
    else $error("hold limit not zero after reset");

  io_lane_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    cfg_wr && hit_io && cfg_be[1]
    |=> io_window_base[7:0] == $past(cfg_wdata[15:8]))
    else $error("io base byte did not take the write");

  grant_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !gnt_sync_q |=> !burst_stop)
    else $error("bus released while still granted");

  stop_after_expiry_a: assert property (@(posedge clk) disable iff (!reset_n)
    burst_stop |-> $past(state_q) == PCICFG_EXPIRED)
    else $error("bus released before the count expired");

  count_step_a: assert property (@(posedge clk) disable iff (!reset_n)
    state_q == PCICFG_COUNT && !frame_start
    |=> cnt_q == $past(cnt_q) - 8'h01)
    else $error("latency count did not step down");

  interval_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    !eeprom_load |=> $stable(access_interval_need))
    else $error("interval byte changed without a load");

endmodule

// >>> pcicfg_pkg.sv
// Behaviour
// - The interrupt routing byte at offset 0x3C is read-write and resets to 0x00.
// - The interrupt pin byte at offset 0x3D always reads 0x01, naming the INTA# line.
// - The I/O base register at 0x10 holds the address in its upper 24 bits only, a 256-byte window.
// - Bit 0 of the I/O base register is a read-write flag marking the address as valid.
// - The I/O base register resets to all zeros.
// - The hold limit byte at 0x0D resets to 0x00; bits 7:3 are writable, in 8-clock units.
// - The latency counter restarts each time the device asserts FRAME# as bus master.
// - Once the count has expired and the grant is removed, the device ends its burst one clock after expiry, or three clocks after a later grant removal.
// - The read-only access interval byte counts 250 ns units, loaded from the EEPROM.
package pcicfg_pkg;

  // Configuration byte offsets
  localparam logic [7:0] PCICFG_OFS_HOLD_LIMIT = 8'h0d;
  localparam logic [7:0] PCICFG_OFS_IO_BASE    = 8'h10;
  localparam logic [7:0] PCICFG_OFS_IRQ_LINE   = 8'h3c;
  localparam logic [7:0] PCICFG_OFS_IRQ_PIN    = 8'h3d;
  localparam logic [7:0] PCICFG_OFS_INTERVAL   = 8'h3f;

  // Dword index of each byte offset
  localparam logic [5:0] PCICFG_DW_HOLD = PCICFG_OFS_HOLD_LIMIT[7:2];
  localparam logic [5:0] PCICFG_DW_IO   = PCICFG_OFS_IO_BASE[7:2];
  localparam logic [5:0] PCICFG_DW_IRQ  = PCICFG_OFS_IRQ_LINE[7:2];

  // Reset and constant values
  localparam logic [7:0]  PCICFG_IRQ_LINE_RST = 8'h00;
  localparam logic [7:0]  PCICFG_IRQ_PIN_VAL  = 8'h01;
  localparam logic [7:0]  PCICFG_HOLD_RST     = 8'h00;
  localparam logic [7:0]  PCICFG_HOLD_MASK    = 8'hf8;
  localparam logic [23:0] PCICFG_IO_ADDR_RST  = 24'h000000;
  localparam logic        PCICFG_IO_VALID_RST = 1'b0;
  localparam logic [6:0]  PCICFG_IO_RSVD      = 7'h00;
  localparam logic [7:0]  PCICFG_ZERO_BYTE    = 8'h00;

  // Interval byte counts in these units
  localparam int PCICFG_INTERVAL_UNIT_NS = 250;

  // Burst latency states, Gray along idle -> count -> expired
  typedef enum logic [1:0] {
    PCICFG_IDLE    = 2'b00,
    PCICFG_COUNT   = 2'b01,
    PCICFG_EXPIRED = 2'b11
  } pcicfg_state_e;

endpackage

// >>> testbench.sv
`timescale 1ns/100ps
module testbench
  import pcicfg_pkg::*;
;
  localparam logic [7:0] IVL = 8'h5a;
  logic        clk = 1'b0;
  logic        reset_n, cfg_rd, cfg_wr, frame_start, burst_done, gnt_n, eeprom_load;
  logic        cfg_ack, io_base_valid_flag, burst_stop, go, grant_off, stall;
  logic [7:0]  cfg_addr, eeprom_setup_field, irq_routing_byte, bus_hold_limit;
  logic [7:0]  access_interval_need;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [23:0] io_window_base;
  int          err_count = 0;
  int          checks_done = 0;
  int          cycles = 0;

  // 50 ns period
  always #25 clk = ~clk;

  pcicfg_header #(.INTERVAL_RESET(IVL)) pcicfg_header_i (.clk, .reset_n, .cfg_rd, .cfg_wr,
    .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_ack, .frame_start, .burst_done, .gnt_n,
    .eeprom_load, .eeprom_setup_field, .irq_routing_byte, .io_window_base,
    .io_base_valid_flag, .bus_hold_limit, .access_interval_need, .burst_stop);

  pcicfg_arb_model pcicfg_arb_model_i (.clk, .reset_n, .go, .grant_off, .stall, .burst_stop,
    .frame_start, .burst_done, .gnt_n);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Checking and access tasks; accesses chain back to back, idle ends a run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d, input logic [31:0] exp, input logic ak);
    cfg_wr = w;
    cfg_rd = r;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    @(negedge clk);
    chk(cfg_rdata, exp);
    chk({31'h0, cfg_ack}, {31'h0, ak});
  endtask

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    acc(1'b1, 1'b0, a, be, d, 32'h0, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic ak);
    acc(1'b0, 1'b1, a, 4'h0, 32'h0, exp, ak);
  endtask

  task automatic idle;
    acc(1'b0, 1'b0, 8'h00, 4'h0, 32'h0, 32'h0, 1'b0);
  endtask

  // Counts negedges until the stop level shows, then holds and releases the bus
  task automatic wait_stop(input int exp_n);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      go = 1'b0;
      n++;
    end
    while (burst_stop !== 1'b1 && n < 300);
    chk(n, exp_n);
    repeat (3) @(negedge clk);
    chk({31'h0, burst_stop}, 32'h1);
    stall = 1'b0;
    repeat (3) @(negedge clk);
    chk({31'h0, burst_stop}, 32'h0);
    stall = 1'b1;
  endtask

  task automatic frame(input logic [7:0] lim);
    wr(PCICFG_OFS_HOLD_LIMIT, 4'b0010, {16'h0, lim, 8'h00});
    idle;
    chk({24'h0, bus_hold_limit}, {24'h0, lim & 8'hf8});
    go = 1'b1;
    wait_stop(int'(lim & 8'hf8) + 3);
  endtask

  task automatic tally_and_finish;
    $display("checks_done=%0d err_count=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_count++;
      tally_and_finish;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    reset_n = 1'b0;
    cfg_rd = 1'b0;
    cfg_wr = 1'b0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0;
    eeprom_load = 1'b0;
    eeprom_setup_field = 8'h00;
    go = 1'b0;
    grant_off = 1'b1;
    stall = 1'b1;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    rd(PCICFG_OFS_IRQ_LINE, {IVL, 16'h0001, 8'h00}, 1'b1);
    rd(PCICFG_OFS_IO_BASE, 32'h0, 1'b1);
    rd(8'h0c, 32'h0, 1'b1);
    wr(PCICFG_OFS_IRQ_LINE, 4'hf, 32'hffffffff);
    rd(PCICFG_OFS_IRQ_LINE, {IVL, 16'h0001, 8'hff}, 1'b1);
    wr(PCICFG_OFS_IRQ_LINE, 4'h1, 32'h0000000f);
    rd(PCICFG_OFS_IRQ_LINE, {IVL, 16'h0001, 8'h0f}, 1'b1);
    wr(PCICFG_OFS_IO_BASE, 4'hf, 32'h12345601);
    rd(PCICFG_OFS_IO_BASE, 32'h12345601, 1'b1);
    wr(PCICFG_OFS_IO_BASE, 4'h1, 32'h0);
    rd(PCICFG_OFS_IO_BASE, 32'h12345600, 1'b1);
    acc(1'b1, 1'b0, 8'h20, 4'hf, 32'hffffffff, 32'h0, 1'b0);
    rd(8'h20, 32'h0, 1'b0);
    idle;
    chk({8'h0, io_window_base}, 32'h00123456);
    chk({31'h0, io_base_valid_flag}, 32'h0);
    chk({24'h0, irq_routing_byte}, 32'h0f);
    // Auto-initialisation loads the interval byte
    eeprom_setup_field = 8'h3c;
    eeprom_load = 1'b1;
    @(negedge clk);
    eeprom_load = 1'b0;
    rd(PCICFG_OFS_IRQ_LINE, 32'h3c00010f, 1'b1);
    idle;
    chk({24'h0, access_interval_need}, 32'h3c);
    // Limits: zero, one unit of eight clocks, a longer count; reserved bits kept zero
    frame(8'h00);
    frame(8'h08);
    frame(8'h20);
    // A second frame start restarts the count
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    repeat (3) @(negedge clk);
    go = 1'b1;
    wait_stop(35);
    // Expired but still granted: no release until the grant goes
    grant_off = 1'b0;
    repeat (3) @(negedge clk);
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    repeat (45) @(negedge clk);
    chk({31'h0, burst_stop}, 32'h0);
    grant_off = 1'b1;
    wait_stop(4);
    tally_and_finish;
  end
endmodule
